/* File: logic/cfg_pkg.sv */
/*
  Constants for the power-up switch configuration decoder: switch
  positions, status field layout, register offsets, baud table.
  Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package cfg_pkg;

  ////////////////////////////////////////////////////////////////////
  // Switch bank: index 0 is switch one, bit high means switch ON
  localparam int unsigned SW_COUNT     = 12;
  localparam int unsigned SW_ADDR_LSB  = 0;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned SW_PAR_EN    = 4;
  localparam int unsigned SW_PAR_SENSE = 5;
  localparam int unsigned SW_STOP      = 6;
  localparam int unsigned SW_DATA      = 7;
  localparam int unsigned SW_BAUD_LSB  = 8;
  localparam int unsigned BAUD_CODE_W  = 3;
  localparam int unsigned SW_MODE      = 11;

  ////////////////////////////////////////////////////////////////////
  // Clock and baud table
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RATE_W = 15;
  localparam int unsigned DIV_W  = 18;
  localparam logic [RATE_W-1:0] BAUD_150   = 15'h0096;
  localparam logic [RATE_W-1:0] BAUD_300   = 15'h012C;
  localparam logic [RATE_W-1:0] BAUD_600   = 15'h0258;
  localparam logic [RATE_W-1:0] BAUD_1200  = 15'h04B0;
  localparam logic [RATE_W-1:0] BAUD_2400  = 15'h0960;
  localparam logic [RATE_W-1:0] BAUD_4800  = 15'h12C0;
  localparam logic [RATE_W-1:0] BAUD_9600  = 15'h2580;
  localparam logic [RATE_W-1:0] BAUD_19200 = 15'h4B00;

  ////////////////////////////////////////////////////////////////////
  // Register map (byte offsets) and field positions
  localparam int unsigned REG_AW = 8;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [REG_AW-1:0] OFS_SWITCH = 8'h04;
  localparam logic [REG_AW-1:0] OFS_RATE   = 8'h08;
  localparam logic [REG_AW-1:0] OFS_DIV    = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_CTRL   = 8'h10;
  localparam int unsigned ST_ADDR_LSB = 0;
  localparam int unsigned ST_AUTO     = 4;
  localparam int unsigned ST_PAR_EN   = 5;
  localparam int unsigned ST_PAR_ODD  = 6;
  localparam int unsigned ST_STOP2    = 7;
  localparam int unsigned ST_DATA8    = 8;
  localparam int unsigned ST_BAUD_LSB = 9;
  localparam int unsigned ST_UNSUP    = 12;
  localparam int unsigned ST_VALID    = 13;
  localparam int unsigned CTRL_CHK_EN = 0;
  localparam logic        CTRL_CHK_RST = 1'h1;

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_SNAP,
    ST_DECODE,
    ST_READY
  } boot_e;

endpackage

/* File: logic/switch_snapshot.sv */
/*
  Power-up snapshot of the switch bank.
  Assumes switch levels are static and synchronous to mclk.
*/
`timescale 1ns/1ps
module switch_snapshot #(
  parameter int unsigned W = 12
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Switch levels
  input  wire logic [W-1:0] sw_on,
  // Held copy
  output logic      [W-1:0] snap_ff,
  output logic              loaded_ff
);

  ////////////////////////////////////////////////////////////////////
  // Capture once on the first edge after release, then hold
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      snap_ff   <= '0;
      loaded_ff <= 1'b0;
    end else if (!loaded_ff) begin
      snap_ff   <= sw_on;
      loaded_ff <= 1'b1;
    end
  end

endmodule // switch_snapshot

/* File: logic/baud_lookup.sv */
/*
  Baud code to rate and bit-period divisor, registered.
  Assumes the code is stable once decoded.
*/
`timescale 1ns/1ps
module baud_lookup import cfg_pkg::*; #(
  parameter int unsigned CLK_RATE = CLK_HZ
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  // Code in
  input  wire logic [BAUD_CODE_W-1:0] code,
  // Rate and divisor out
  output logic      [RATE_W-1:0]      rate_ff,
  output logic      [DIV_W-1:0]       div_ff
);

  ////////////////////////////////////////////////////////////////////
  // Table: code 0 is all switches ON
  function automatic logic [RATE_W-1:0] rate_of(
    input logic [BAUD_CODE_W-1:0] c
  );
    case (c)
      3'h0:    rate_of = BAUD_150;
      3'h1:    rate_of = BAUD_300;
      3'h2:    rate_of = BAUD_600;
      3'h3:    rate_of = BAUD_1200;
      3'h4:    rate_of = BAUD_2400;
      3'h5:    rate_of = BAUD_4800;
      3'h6:    rate_of = BAUD_9600;
      default: rate_of = BAUD_19200;
    endcase
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rate_ff <= '0;
      div_ff  <= '0;
    end else begin
      rate_ff <= rate_of(code);
      div_ff  <= DIV_W'(CLK_RATE / int'(rate_of(code)));
    end
  end

endmodule // baud_lookup

/* File: logic/dip_switch_config_decoder.sv */
/*
  Power-up configuration decoder for a twelve-position switch bank.
  Holds the serial frame format, bus address or preset select and
  control mode, and shows them over an AHB-Lite slave.
  Assumes switch inputs synchronous to mclk and a single AHB master.
*/
`timescale 1ns/1ps

module dip_switch_config_decoder import cfg_pkg::*; #(
  parameter int unsigned CLK_RATE = CLK_HZ
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  // Switch bank, bit set when switch ON
  input  wire logic [SW_COUNT-1:0]    sw_on,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Decoded configuration
  output logic      [ADDR_W-1:0]      bus_addr,
  output logic      [ADDR_W-1:0]      preset_sel,
  output logic                        auto_mode,
  output logic                        parity_en,
  output logic                        parity_odd,
  output logic                        stop_two,
  output logic                        data_eight,
  output logic      [BAUD_CODE_W-1:0] baud_code,
  output logic      [RATE_W-1:0]      baud_rate,
  output logic      [DIV_W-1:0]       bit_div,
  output logic                        fmt_unsupported,
  output logic                        cfg_valid
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [SW_COUNT-1:0]    snap_ff;
  logic                   loaded_ff;
  boot_e                  boot_ff;
  boot_e                  nxt_boot;
  logic [ADDR_W-1:0]      sel_val;
  logic [ADDR_W-1:0]      bus_addr_ff;
  logic [ADDR_W-1:0]      preset_ff;
  logic                   auto_ff;
  logic                   par_en_ff;
  logic                   par_odd_ff;
  logic                   stop2_ff;
  logic                   data8_ff;
  logic [BAUD_CODE_W-1:0] code_ff;
  logic [RATE_W-1:0]      rate_ff;
  logic [DIV_W-1:0]       div_ff;
  logic                   unsup_fmt;
  logic                   unsup_ff;
  logic                   valid_ff;
  logic                   chk_en_ff;
  logic                   wr_pend_ff;
  logic [REG_AW-1:0]      wr_ofs_ff;
  logic [31:0]            hrdata_ff;
  logic                   hreadyout_ff;
  logic                   hresp_ff;
  logic                   addr_phase;
  logic [31:0]            status_word;

  ////////////////////////////////////////////////////////////////////
  // Power-up snapshot
  switch_snapshot #(
    .W         (SW_COUNT)
  ) u_snap (
    .mclk      (mclk),
    .resetn    (resetn),
    .sw_on     (sw_on),
    .snap_ff   (snap_ff),
    .loaded_ff (loaded_ff)
  );

  ////////////////////////////////////////////////////////////////////
  // Boot sequence: snapshot, decode, rate lookup
  always_comb begin
    nxt_boot = boot_ff;
    case (boot_ff)
      ST_RESET: begin
        nxt_boot = ST_SNAP;
      end
      ST_SNAP: begin
        if (loaded_ff) begin
          nxt_boot = ST_DECODE;
        end
      end
      ST_DECODE: begin
        nxt_boot = ST_READY;
      end
      ST_READY: begin
        nxt_boot = ST_READY;
      end
      default: begin
        nxt_boot = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      boot_ff <= ST_RESET;
    end else begin
      boot_ff <= nxt_boot;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Switches one to four: OFF reads as 1
  assign sel_val = ~snap_ff[SW_ADDR_LSB +: ADDR_W];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_addr_ff <= '0;
    end else if (loaded_ff) begin
      bus_addr_ff <= snap_ff[SW_MODE] ? '0 : sel_val;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      preset_ff <= '0;
    end else if (loaded_ff) begin
      preset_ff <= snap_ff[SW_MODE] ? sel_val : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      auto_ff <= 1'b0;
    end else if (loaded_ff) begin
      auto_ff <= snap_ff[SW_MODE];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame format, one flag per switch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      par_en_ff <= 1'b0;
    end else if (loaded_ff) begin
      par_en_ff <= ~snap_ff[SW_PAR_EN];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      par_odd_ff <= 1'b0;
    end else if (loaded_ff) begin
      par_odd_ff <= ~snap_ff[SW_PAR_SENSE];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stop2_ff <= 1'b0;
    end else if (loaded_ff) begin
      stop2_ff <= ~snap_ff[SW_STOP];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data8_ff <= 1'b0;
    end else if (loaded_ff) begin
      data8_ff <= ~snap_ff[SW_DATA];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Baud code: eleven is the MSB, OFF reads as 1
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      code_ff <= '0;
    end else if (loaded_ff) begin
      code_ff <= ~snap_ff[SW_BAUD_LSB +: BAUD_CODE_W];
    end
  end

  baud_lookup #(
    .CLK_RATE (CLK_RATE)
  ) u_baud (
    .mclk     (mclk),
    .resetn   (resetn),
    .code     (code_ff),
    .rate_ff  (rate_ff),
    .div_ff   (div_ff)
  );

  ////////////////////////////////////////////////////////////////////
  // Unsupported frame formats, flag gated by software
  assign unsup_fmt = (!data8_ff && !stop2_ff && !par_en_ff) ||
                     (data8_ff && stop2_ff && par_en_ff);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      unsup_ff <= 1'b0;
    end else if (boot_ff == ST_READY) begin
      unsup_ff <= chk_en_ff && unsup_fmt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Valid once the rate lookup has settled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      valid_ff <= 1'b0;
    end else if (boot_ff == ST_DECODE) begin
      valid_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase
  function automatic logic word_access(
    input logic       sel,
    input logic       rdy,
    input logic [1:0] trans,
    input logic [2:0] size
  );
    word_access = sel && rdy && trans[1] && (size == HSIZE_WORD);
  endfunction

  assign addr_phase = word_access(hsel, hready, htrans, hsize);

  // Pending write held into its data phase
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_ff <= 1'b0;
    end else if (hready) begin
      wr_pend_ff <= addr_phase && hwrite;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ofs_ff <= '0;
    end else if (hready) begin
      wr_ofs_ff <= haddr[REG_AW-1:0];
    end
  end

  // Control register: the only writable one
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chk_en_ff <= CTRL_CHK_RST;
    end else if (wr_pend_ff && hready && (wr_ofs_ff == OFS_CTRL)) begin
      chk_en_ff <= hwdata[CTRL_CHK_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, captured at the address phase edge
  always_comb begin
    status_word                            = WORD_ZERO;
    status_word[ST_ADDR_LSB +: ADDR_W]     = auto_ff ? preset_ff : bus_addr_ff;
    status_word[ST_AUTO]                   = auto_ff;
    status_word[ST_PAR_EN]                 = par_en_ff;
    status_word[ST_PAR_ODD]                = par_odd_ff;
    status_word[ST_STOP2]                  = stop2_ff;
    status_word[ST_DATA8]                  = data8_ff;
    status_word[ST_BAUD_LSB +: BAUD_CODE_W] = code_ff;
    status_word[ST_UNSUP]                  = unsup_ff;
    status_word[ST_VALID]                  = valid_ff;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata_ff <= WORD_ZERO;
    end else if (addr_phase && !hwrite) begin
      case (haddr[REG_AW-1:0])
        OFS_STATUS: hrdata_ff <= status_word;
        OFS_SWITCH: hrdata_ff <= {{(32-SW_COUNT){1'b0}}, snap_ff};
        OFS_RATE:   hrdata_ff <= {{(32-RATE_W){1'b0}}, rate_ff};
        OFS_DIV:    hrdata_ff <= {{(32-DIV_W){1'b0}}, div_ff};
        OFS_CTRL:   hrdata_ff <= {{31{1'b0}}, chk_en_ff};
        default:    hrdata_ff <= WORD_ZERO;
      endcase
    end
  end

  // Zero wait states
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= 1'b1;
    end
  end

  // Response is always OKAY
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hresp_ff <= HRESP_OKAY;
    end else begin
      hresp_ff <= HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, each from a flip-flop
  assign hrdata          = hrdata_ff;
  assign hreadyout       = hreadyout_ff;
  assign hresp           = hresp_ff;
  assign bus_addr        = bus_addr_ff;
  assign preset_sel      = preset_ff;
  assign auto_mode       = auto_ff;
  assign parity_en       = par_en_ff;
  assign parity_odd      = par_odd_ff;
  assign stop_two        = stop2_ff;
  assign data_eight      = data8_ff;
  assign baud_code       = code_ff;
  assign baud_rate       = rate_ff;
  assign bit_div         = div_ff;
  assign fmt_unsupported = unsup_ff;
  assign cfg_valid       = valid_ff;

endmodule // dip_switch_config_decoder

/* File: tb/serial_port_model.sv */
/*
  Behavioural serial port on the decoder's far side.
  Assumes frame settings are levels qualified by cfg_valid.
*/
`timescale 1ns/1ps
module serial_port_model (
  // Frame settings from the decoder
  input  wire logic       cfg_valid,
  input  wire logic       parity_en,
  input  wire logic       stop_two,
  input  wire logic       data_eight,
  // Frame length and acceptance
  output logic      [3:0] frame_bits,
  output logic            fmt_ok
);
  ////////////////////////////////////////////////////////////////////
  // Start bit, data, optional parity, stop bits
  assign frame_bits = 4'h1 + (data_eight ? 4'h8 : 4'h7) + {3'h0, parity_en}
                      + (stop_two ? 4'h2 : 4'h1);
  // Port refuses the two unsupported layouts
  assign fmt_ok = cfg_valid & ~((~data_eight & ~stop_two & ~parity_en)
                  | (data_eight & stop_two & parity_en));
endmodule // serial_port_model

/* File: tb/dip_switch_config_decoder_assertions.sv */
/*
  Port checks for the switch configuration decoder.
  Assumes one clock domain; bound to the top module.
*/
`timescale 1ns/1ps
module cfg_decoder_checker import cfg_pkg::*; #(
  parameter int unsigned CLK_RATE = CLK_HZ
) (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   resetn,
  // Bus
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  // Decoded configuration
  input wire logic [ADDR_W-1:0]      bus_addr,
  input wire logic [ADDR_W-1:0]      preset_sel,
  input wire logic                   auto_mode,
  input wire logic                   parity_en,
  input wire logic                   stop_two,
  input wire logic                   data_eight,
  input wire logic [BAUD_CODE_W-1:0] baud_code,
  input wire logic [RATE_W-1:0]      baud_rate,
  input wire logic [DIV_W-1:0]       bit_div,
  input wire logic                   fmt_unsupported,
  input wire logic                   cfg_valid
);
  logic rd_req;
  assign rd_req = hsel && hready && htrans[1] && !hwrite && hsize == HSIZE_WORD;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////
  sequence s_rd_sw;
    rd_req && haddr[7:0] == OFS_SWITCH && cfg_valid && !auto_mode;
  endsequence
  sequence s_rd_st;
    rd_req && haddr[7:0] == OFS_STATUS && cfg_valid;
  endsequence

  property p_addr_inv;
    s_rd_sw |=> hrdata[3:0] == ~bus_addr;
  endproperty
  property p_status;
    s_rd_st |=> hrdata[ST_BAUD_LSB +: BAUD_CODE_W] == baud_code
                && hrdata[ST_AUTO] == auto_mode && hrdata[ST_VALID];
  endproperty
  property p_user;
    cfg_valid && !auto_mode |-> preset_sel == 4'h0;
  endproperty
  property p_auto;
    cfg_valid && auto_mode |-> bus_addr == 4'h0;
  endproperty
  property p_hold;
    cfg_valid |=> $stable({bus_addr, preset_sel, auto_mode, parity_en,
                           stop_two, data_eight, baud_code});
  endproperty
  property p_valid_time;
    $rose(resetn) |-> ##[1:4] cfg_valid;
  endproperty
  property p_sticky;
    cfg_valid |=> cfg_valid;
  endproperty
  property p_baud;
    cfg_valid |-> baud_rate == (15'h0096 << baud_code);
  endproperty
  property p_div;
    cfg_valid |-> bit_div == DIV_W'(CLK_RATE / baud_rate);
  endproperty
  property p_unsup;
    fmt_unsupported |-> (!data_eight && !stop_two && !parity_en)
                        || (data_eight && stop_two && parity_en);
  endproperty

  a_addr_inv: assert property (p_addr_inv)
    else $error("switch read disagrees with bus address");
  a_status: assert property (p_status)
    else $error("status read disagrees with outputs");
  a_user: assert property (p_user)
    else $error("preset select active in user mode");
  a_auto: assert property (p_auto)
    else $error("bus address active in automatic mode");
  a_hold: assert property (p_hold)
    else $error("decoded settings changed after capture");
  a_valid_time: assert property (p_valid_time)
    else $error("configuration not valid in time");
  a_sticky: assert property (p_sticky)
    else $error("valid flag dropped");
  a_baud: assert property (p_baud)
    else $error("baud rate wrong for code");
  a_div: assert property (p_div)
    else $error("bit divisor wrong");
  a_unsup: assert property (p_unsup)
    else $error("unsupported flag on a legal format");
endmodule // cfg_decoder_checker

bind dip_switch_config_decoder cfg_decoder_checker #(.CLK_RATE(CLK_RATE)) u_chk (
  .mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata,
  .bus_addr, .preset_sel, .auto_mode, .parity_en, .stop_two, .data_eight,
  .baud_code, .baud_rate, .bit_div, .fmt_unsupported, .cfg_valid
);

/* File: tb/dip_switch_config_decoder_tb_top.sv */
/*
  Self-checking bench for the switch configuration decoder.
  Assumes the bench is the only AHB master; hready is hreadyout.
*/
`timescale 1ns/1ps
module dip_switch_config_decoder_tb_top import cfg_pkg::*;;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] sw_on = 12'h000;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, auto_mode, parity_en, parity_odd, stop_two;
  logic        data_eight, fmt_unsupported, cfg_valid, fmt_ok;
  logic [3:0]  bus_addr, preset_sel, frame_bits;
  logic [2:0]  baud_code;
  logic [14:0] baud_rate;
  logic [17:0] bit_div;
  int          err_total, check_count;

  always #25 mclk = ~mclk;
  assign hready = hreadyout;

  dip_switch_config_decoder DUT (
    .mclk, .resetn, .sw_on, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .bus_addr, .preset_sel, .auto_mode,
    .parity_en, .parity_odd, .stop_two, .data_eight, .baud_code, .baud_rate,
    .bit_div, .fmt_unsupported, .cfg_valid
  );
  serial_port_model u_port (
    .cfg_valid, .parity_en, .stop_two, .data_eight, .frame_bits, .fmt_ok
  );

  ////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("Checks made %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_total++;
      tally_and_finish;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    hsize <= HSIZE_WORD;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask

  // Expected STATUS word from switch levels
  function automatic logic [31:0] exp_status(input logic [11:0] s, input logic ce);
    logic pe, s2, d8;
    pe = !s[4];
    s2 = !s[6];
    d8 = !s[7];
    exp_status = {18'h0, 1'b1, ce & ((!d8 & !s2 & !pe) | (d8 & s2 & pe)),
                  ~s[10:8], d8, s2, !s[5], pe, s[11], ~s[3:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] s;
    logic [31:0] d, r, st;
    logic [3:0]  fb;
    logic [3:0]  a4;
    int          i, j;
    void'($urandom(32'h362982d6));
    for (i = 0; i < 12; i++) begin
      s = 12'($urandom);
      s[11] = i[0];
      if (i < 8) s[10:8] = ~i[2:0];
      if (i == 8) {s[7], s[6], s[4]} = 3'h7;
      if (i == 9) {s[7], s[6], s[4]} = 3'h0;
      a4 = ~s[3:0];
      @(posedge mclk);
      resetn <= 1'b0;
      sw_on <= s;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      sw_on <= ~s;
      j = 0;
      while (cfg_valid !== 1'b1 && j < 20) begin
        @(posedge mclk);
        j++;
      end
      repeat (2) @(posedge mclk);
      chk("cfg_valid", 32'h1, 32'(cfg_valid));
      r = 32'h96 << ~s[10:8];
      st = exp_status(s, 1'b1);
      fb = 4'h1 + (s[7] ? 4'h7 : 4'h8) + {3'h0, !s[4]} + (s[6] ? 4'h1 : 4'h2);
      xfer(1'b0, OFS_CTRL, 32'h0, d);
      chk("ctrl", 32'h1, d);
      xfer(1'b0, OFS_STATUS, 32'h0, d);
      chk("status", st, d);
      xfer(1'b0, OFS_SWITCH, 32'h0, d);
      chk("switch", {20'h0, s}, d);
      xfer(1'b0, OFS_RATE, 32'h0, d);
      chk("rate", r, d);
      xfer(1'b0, OFS_DIV, 32'h0, d);
      chk("div", CLK_HZ / r, d);
      chk("bus_addr", 32'(s[11] ? 4'h0 : a4), 32'(bus_addr));
      chk("preset", 32'(s[11] ? a4 : 4'h0), 32'(preset_sel));
      chk("frame", 32'(fb), 32'(frame_bits));
      chk("fmt_ok", 32'(!st[12]), 32'(fmt_ok));
      chk("outputs", 32'(st[13:0]), 32'({cfg_valid, fmt_unsupported, baud_code, data_eight,
          stop_two, parity_odd, parity_en, auto_mode, bus_addr | preset_sel}));
      chk("rate_out", r, 32'(baud_rate));
      chk("div_out", CLK_HZ / r, 32'(bit_div));
      chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
      chk("hreadyout", 32'h1, 32'(hreadyout));
      xfer(1'b1, OFS_CTRL, 32'h0, d);
      xfer(1'b1, OFS_STATUS, 32'hFFFFFFFF, d);
      xfer(1'b0, OFS_STATUS, 32'h0, d);
      chk("status masked", exp_status(s, 1'b0), d);
      chk("unsup masked", 32'h0, 32'(fmt_unsupported));
      xfer(1'b0, 8'h14, 32'h0, d);
      chk("unmapped", 32'h0, d);
    end
    tally_and_finish;
  end

  initial begin
    #5000000;
    err_total++;
    tally_and_finish;
  end
endmodule // dip_switch_config_decoder_tb_top
